// *** include/urx_if.sv ***
// Serial line between remote sender and receiver
`timescale 1ns/1ps
`default_nettype none
interface urx_if;
   logic line; // Idle high
   modport sender (output line);
   modport receiver (input line);
endinterface
`default_nettype wire

// *** include/urx_pkg.sv ***
// Package for the receive-side serial port block and its remote sender
// ==========================================================================
// Notes on behaviour
// - Each held character keeps its framing flag
// - Missing stop bit marks framing error
// - Framing flag read-only; pop advances it
// - Port disable clears flag; receive disable keeps
// - Framing error alone raises no interrupt
// - Reception continues after framing error
// - All-bad FIFO keeps flag set on reads
// - Software reads framing flag before data
// - Two-deep FIFO; third character sets overrun
// - Overrun blocks new characters, old readable
// - Overrun cleared only by disabling receive/port
// - Nine-bit mode shifts nine data bits
// - Ninth bit of oldest shown; read first
// - Address detect works with nine-bit mode
// - Address mode with nine-bit mode keeps only ninth-bit-set characters; in eight-bit mode it keeps all
// - Software drops address mode after match
package urx_pkg;
   // ======================================================================
   // Timing
   localparam int unsigned URX_CLK_MHZ = 250;
   localparam logic [15:0] URX_BIT_CYC = 16'h0010; // Cycles per bit
   localparam logic [15:0] URX_HALF_CYC = 16'h0008;
   localparam int unsigned URX_FIFO_DEPTH = 2;
   // ======================================================================
   // APB register offsets
   localparam logic [7:0] URX_CTRL_OFS = 8'h00;
   localparam logic [7:0] URX_STAT_OFS = 8'h04;
   localparam logic [7:0] URX_DATA_OFS = 8'h08;
   localparam logic [7:0] URX_IRQ_OFS = 8'h0C;
   localparam logic [7:0] URX_MASK_OFS = 8'h10;
   localparam logic [7:0] URX_TXD_OFS = 8'h14;
   // Control bit positions
   localparam int unsigned URX_PORT_EN_BIT = 0;
   localparam int unsigned URX_RX_EN_BIT = 1;
   localparam int unsigned URX_NINE_EN_BIT = 2;
   localparam int unsigned URX_ADDR_EN_BIT = 3;
   // Status bit positions
   localparam int unsigned URX_R9D_BIT = 0;
   localparam int unsigned URX_OVR_BIT = 1;
   localparam int unsigned URX_FRM_BIT = 2;
   localparam int unsigned URX_AVAIL_BIT = 3;
   localparam int unsigned URX_CNT_LSB = 4;
   // Interrupt status bits
   localparam int unsigned URX_EV_RX = 0;
   localparam int unsigned URX_EV_OVR = 1;
   localparam logic [3:0] URX_CTRL_RST = 4'h0;
   localparam logic [1:0] URX_MASK_RST = 2'h0;
   typedef enum logic [1:0] {
      URX_IDLE = 2'b00,
      URX_START = 2'b01,
      URX_DATA = 2'b10,
      URX_STOP = 2'b11
   } urx_state_e;
endpackage

// *** rtl/urx_receiver.sv ***
// Receiver with two-deep FIFO, error flags, address detection and APB
`timescale 1ns/1ps
`default_nettype none
module urx_receiver
   import urx_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   urx_if.receiver link,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq
);
   import urx_pkg::*;

   typedef struct packed {
      logic sync1;
      logic sync2;
      urx_state_e st;
      logic [15:0] cnt;
      logic [3:0] bitIdx;
      logic [8:0] shift;
      logic [1:0][9:0] fifo; // {framing_error_flag, ninth, data}
      logic rdPtr;
      logic [1:0] level;
      logic overrun;
      logic popArm; // DATA read seen in setup, pop armed
      logic [3:0] ctrl;
      logic [1:0] irqStat;
      logic [1:0] irqMask;
      logic [31:0] rdata;
   } urx_reg_s;

   urx_reg_s q, d;
   logic acc, wr, rd;
   logic portEn, rxEn, nine;
   logic notEmpty;
   logic [3:0] nBits;
   logic done, stopOk, keep, pop, push;
   logic [1:0] evSet;
   logic [9:0] top;

   assign acc = psel & penable;
   assign wr = acc & pwrite;
   // Reads are captured in the setup cycle, so the word stands on prdata
   // from a flip-flop through the access cycle; with pready tied high the
   // master takes it at the end of that cycle
   assign rd = psel & ~penable & ~pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = q.rdata;
   assign irq = |(q.irqStat & q.irqMask);
   assign portEn = q.ctrl[URX_PORT_EN_BIT];
   assign rxEn = q.ctrl[URX_RX_EN_BIT];
   assign nine = q.ctrl[URX_NINE_EN_BIT];
   assign nBits = nine ? 4'h9 : 4'h8;
   assign top = q.fifo[q.rdPtr];
   assign notEmpty = q.level != 2'd0;

   always_comb begin
      d = q;
      done = 1'b0;
      stopOk = 1'b0;
      // ====================================================================
      // Input synchroniser
      d.sync1 = link.line;
      d.sync2 = q.sync1;
      // ====================================================================
      // Bit sampling; runs only while the port and receive are enabled
      if (!(portEn && rxEn)) begin
         d.st = URX_IDLE;
         d.cnt = 16'h0000;
      end else begin
         case (q.st)
            URX_IDLE: begin
               if (!q.sync2) begin
                  d.st = URX_START;
                  d.cnt = URX_HALF_CYC;
               end
            end
            URX_START: begin
               if (q.cnt == 16'h0001) begin
                  // False start glitches are dropped
                  d.st = q.sync2 ? URX_IDLE : URX_DATA;
                  d.cnt = URX_BIT_CYC;
                  d.bitIdx = 4'h0;
               end else begin
                  d.cnt = q.cnt - 16'h0001;
               end
            end
            URX_DATA: begin
               if (q.cnt == 16'h0001) begin
                  d.cnt = URX_BIT_CYC;
                  // LSB first; eight-bit characters end up left aligned in shift[8:1]
                  d.shift = {q.sync2, q.shift[8:1]};
                  d.bitIdx = q.bitIdx + 4'h1;
                  if (q.bitIdx == nBits - 4'h1) begin
                     d.st = URX_STOP;
                  end
               end else begin
                  d.cnt = q.cnt - 16'h0001;
               end
            end
            URX_STOP: begin
               if (q.cnt == 16'h0001) begin
                  done = 1'b1;
                  stopOk = q.sync2;
                  d.st = URX_IDLE;
               end else begin
                  d.cnt = q.cnt - 16'h0001;
               end
            end
            default: d.st = URX_IDLE;
         endcase
      end
      // ====================================================================
      // Character placement
      keep = done && (!q.ctrl[URX_ADDR_EN_BIT] || !nine
             || q.shift[8]);
      // The pop was armed in the setup cycle, so the entry that leaves is
      // the one whose word stands on prdata in this access cycle
      pop = acc && !pwrite && q.popArm && notEmpty;
      push = keep && !q.overrun && (q.level != 2'd2 || pop);
      evSet = 2'b00;
      // Overrun: a whole third character with both slots full, no pop
      if (keep && !q.overrun && q.level == 2'd2 && !pop) begin
         d.overrun = 1'b1;
         evSet[URX_EV_OVR] = 1'b1;
      end
      if (push) begin
         // framing flag stored beside the character. The free slot
         // follows the oldest; with both full and a pop in the same
         // cycle it is the oldest slot itself, which is leaving
         d.fifo[q.rdPtr ^ q.level[0]] = {!stopOk,
            (nine ? q.shift[8] : 1'b0), (nine ? q.shift[7:0] : q.shift[8:1])};
         evSet[URX_EV_RX] = 1'b1;
      end
      if (pop) begin
         d.rdPtr = ~q.rdPtr;
      end
      d.level = q.level + {1'b0, push} - {1'b0, pop};
      // overrun leaves only with receive or port disable
      if (!rxEn || !portEn) begin
         d.overrun = 1'b0;
      end
      // port disable empties FIFO, so framing flag reads clear
      if (!portEn) begin
         d.level = 2'd0;
         d.rdPtr = 1'b0;
         d.fifo = '0;
      end
      // ====================================================================
      // Registers
      d.rdata = 32'h0000_0000;
      d.popArm = 1'b0;
      if (wr) begin
         case (paddr)
            URX_CTRL_OFS: d.ctrl = pwdata[3:0];
            URX_IRQ_OFS: d.irqStat = q.irqStat & ~pwdata[1:0];
            URX_MASK_OFS: d.irqMask = pwdata[1:0];
            default: ;
         endcase
      end
      d.irqStat = d.irqStat | evSet; // Set wins over clear
      if (rd) begin
         case (paddr)
            URX_CTRL_OFS: d.rdata[3:0] = q.ctrl;
            URX_STAT_OFS: begin
               d.rdata[URX_R9D_BIT] = top[8] & notEmpty;
               d.rdata[URX_OVR_BIT] = q.overrun;
               d.rdata[URX_FRM_BIT] = top[9] & notEmpty;
               d.rdata[URX_AVAIL_BIT] = notEmpty;
               d.rdata[URX_CNT_LSB +: 2] = q.level;
            end
            URX_DATA_OFS: begin
               // An empty store reads zero and arms no pop
               if (notEmpty) begin
                  d.rdata[7:0] = top[7:0];
               end
               d.popArm = notEmpty;
            end
            URX_IRQ_OFS: d.rdata[1:0] = q.irqStat;
            URX_MASK_OFS: d.rdata[1:0] = q.irqMask;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
         // Line idles high; a low reset value would fake a start bit
         q.sync1 <= 1'b1;
         q.sync2 <= 1'b1;
         q.st <= URX_IDLE;
         q.ctrl <= URX_CTRL_RST;
         q.irqMask <= URX_MASK_RST;
      end else begin
         q <= d;
      end
   end
endmodule
`default_nettype wire

// *** rtl/urx_sender.sv ***
// Remote sender: shifts one character onto the line on request
`timescale 1ns/1ps
`default_nettype none
module urx_sender
   import urx_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   urx_if.sender link,
   input wire logic sendValid,
   input wire logic [8:0] sendData,
   input wire logic sendNine,
   input wire logic badStop,
   output logic sendReady
);
   import urx_pkg::*;

   typedef struct packed {
      logic busy;
      logic line;
      logic [11:0] frame;
      logic [3:0] left;
      logic [15:0] cnt;
   } urx_snd_s;

   urx_snd_s q, d;

   assign sendReady = !q.busy;
   assign link.line = q.line;

   always_comb begin
      d = q;
      if (!q.busy) begin
         if (sendValid) begin
            d.busy = 1'b1;
            // Frame LSB first: start, data, stop; a forced low stop
            // lets the far end see a framing error
            d.frame = sendNine ? {1'b1, !badStop, sendData, 1'b0}
                               : {2'b11, !badStop, sendData[7:0], 1'b0};
            d.left = sendNine ? 4'hB : 4'hA;
            d.cnt = 16'h0000;
         end
      end else if (q.cnt == 16'h0000) begin
         d.line = q.frame[0];
         d.frame = {1'b1, q.frame[11:1]};
         d.cnt = URX_BIT_CYC - 16'h0001;
         if (q.left == 4'h0) begin
            d.busy = 1'b0;
            d.line = 1'b1;
         end else begin
            d.left = q.left - 4'h1;
         end
      end else begin
         d.cnt = q.cnt - 16'h0001;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
         q.line <= 1'b1;
      end else begin
         q <= d;
      end
   end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench joining the remote sender to the receiver
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import urx_pkg::*;
   logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, irq;
   logic sendValid, sendNine, badStop, sendReady;
   logic [7:0] paddr;
   logic [8:0] sendData;
   logic [8:0] c [3];
   logic [31:0] pwdata, prdata, rd;
   int failures, comparisons;
   urx_if link();
   urx_receiver urx_receiver_i(.clk_sys(clk_sys), .nrst(nrst), .link(link),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq));
   urx_sender urx_sender_i(.clk_sys(clk_sys), .nrst(nrst), .link(link),
      .sendValid(sendValid), .sendData(sendData), .sendNine(sendNine),
      .badStop(badStop), .sendReady(sendReady));
   urx_monitor urx_monitor_i(.clk_sys(clk_sys), .nrst(nrst),
      .line(link.line), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .prdata(prdata), .irq(irq));
   // ======================================================================
   // Helpers
   function automatic logic [31:0] stf(int l, logic fe, logic oe, logic n);
      return {26'h0, l[1:0], l != 0, fe, oe, n};
   endfunction
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Read data is taken at the very edge at which pready is seen high
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic st(logic [31:0] e);
      apb(1'b0, URX_STAT_OFS, 0);
      chk("stat", e, rd);
   endtask
   // Fixed wait covers one full 9-bit frame plus the receive sync delay
   task automatic snd(logic [8:0] d, logic nine, logic bad);
      sendData <= d;
      sendNine <= nine;
      badStop <= bad;
      sendValid <= 1'b1;
      do @(posedge clk_sys); while (sendReady !== 1'b1);
      sendValid <= 1'b0;
      repeat (240) @(posedge clk_sys);
   endtask
   task automatic end_of_test();
      $display("Counts: %0d comparisons %0d failures", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ======================================================================
   // Clock, watchdog and tests
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial begin
      #100000;
      failures++;
      end_of_test();
   end
   initial begin
      {nrst, psel, penable, pwrite, sendValid, sendNine, badStop} = '0;
      {paddr, pwdata, sendData} = '0;
      void'($urandom(43268));
      for (int i = 0; i < 3; i++) c[i] = 9'($urandom);
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      apb(1'b1, URX_MASK_OFS, 32'h0000_0003);
      apb(1'b1, URX_CTRL_OFS, 32'h0000_0003);
      snd(c[0], 1'b0, 1'b1);
      snd(c[1], 1'b0, 1'b0);
      snd(c[2], 1'b0, 1'b0);
      st(stf(2, 1, 1, 0));
      chk("irq", 1, irq);
      apb(1'b0, URX_IRQ_OFS, 0);
      chk("irqstat", 3, rd);
      apb(1'b1, URX_IRQ_OFS, 32'h0000_0003);
      chk("irqclr", 0, irq);
      apb(1'b0, URX_DATA_OFS, 0);
      chk("data0", c[0][7:0], rd);
      st(stf(1, 0, 1, 0));
      snd(c[0], 1'b0, 1'b0);
      st(stf(1, 0, 1, 0));
      apb(1'b0, URX_DATA_OFS, 0);
      chk("data1", c[1][7:0], rd);
      apb(1'b1, URX_CTRL_OFS, 32'h0000_0001);
      st(stf(0, 0, 0, 0));
      apb(1'b1, URX_CTRL_OFS, 32'h0000_0003);
      snd(c[2], 1'b0, 1'b0);
      st(stf(1, 0, 0, 0));
      apb(1'b0, URX_DATA_OFS, 0);
      apb(1'b0, URX_TXD_OFS, 0);
      chk("unmapped", 0, rd);
      chk("slverr", 0, pslverr);
      $display("Test overrun done");
      snd(c[1], 1'b0, 1'b1);
      snd(c[2], 1'b0, 1'b1);
      st(stf(2, 1, 0, 0));
      apb(1'b1, URX_CTRL_OFS, 32'h0000_0001);
      st(stf(2, 1, 0, 0));
      apb(1'b0, URX_DATA_OFS, 0);
      chk("bad1", c[1][7:0], rd);
      apb(1'b0, URX_STAT_OFS, 0);
      chk("framing_error_flag", 1, rd[2]);
      apb(1'b1, URX_CTRL_OFS, 32'h0000_0000);
      st(stf(0, 0, 0, 0));
      $display("Test framing done");
      apb(1'b1, URX_CTRL_OFS, 32'h0000_000F);
      snd({1'b0, c[0][7:0]}, 1'b1, 1'b0);
      st(stf(0, 0, 0, 0));
      snd({1'b1, c[1][7:0]}, 1'b1, 1'b0);
      st(stf(1, 0, 0, 1));
      apb(1'b0, URX_DATA_OFS, 0);
      chk("addr", c[1][7:0], rd);
      apb(1'b1, URX_CTRL_OFS, 32'h0000_0007);
      snd({1'b0, c[2][7:0]}, 1'b1, 1'b0);
      st(stf(1, 0, 0, 0));
      apb(1'b0, URX_DATA_OFS, 0);
      chk("nine", c[2][7:0], rd);
      $display("Test address done");
      end_of_test();
   end
endmodule
`default_nettype wire

// *** verif/urx_monitor.sv ***
// Checker of the serial line and the receiver bus replies
`timescale 1ns/1ps
`default_nettype none
module urx_monitor
   import urx_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic line,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic irq
);
   import urx_pkg::*;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   logic acc;
   assign acc = psel && penable;
   sequence rdS;
      acc && !pwrite && paddr == URX_STAT_OFS;
   endsequence
   // ======================================================================
   // Assertions
   a_low_width: assert property ($fell(line) |=> !line [*8])
      else $error("Line low shorter than a bit");
   a_high_width: assert property ($rose(line) |=> line [*8])
      else $error("Line high shorter than a bit");
   a_write_zero: assert property (acc && pwrite |-> prdata == 0)
      else $error("Read data not zero during write");
   a_avail_level: assert property (
      rdS |-> prdata[3] == (prdata[5:4] != 0))
      else $error("Available flag disagrees with level");
   a_level_max: assert property (rdS |-> prdata[5:4] <= 2)
      else $error("Level above two");
   a_empty_framing_error_flag: assert property (
      rdS |-> prdata[5:4] != 0 || !prdata[2])
      else $error("Framing flag set with empty store");
   a_unmapped_zero: assert property (
      acc && !pwrite && paddr == URX_TXD_OFS |-> prdata == 0)
      else $error("Unmapped read not zero");
   a_irq_events: assert property (
      acc && !pwrite && paddr == URX_IRQ_OFS |-> prdata[31:2] == 0)
      else $error("Unknown interrupt event bit");
   a_stat_upper: assert property (rdS |-> prdata[31:6] == 0)
      else $error("Status upper bits set");
   c_overrun: cover property (rdS ##0 prdata[1]);
   c_framing: cover property (rdS ##0 prdata[2]);
   c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire
